// >>> common/mcr_pkg.sv
// ****************************************
// Shared constants for the main control word
// ****************************************
package mcr_pkg;
  // Register map, byte addresses
  localparam logic [15:0] MAIN_CONTROL_ADDR = 16'h0000;
  localparam logic [15:0] MAIN_STATUS_ADDR = 16'h0002;
  localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0000;
  // Field positions in the main control word
  localparam int IRQ_EN_LSB = 0;
  localparam int IRQ_EN_MSB = 4;
  localparam int RESV_LSB = 5;
  localparam int RESV_MSB = 10;
  localparam int PAGE_ACCESS_BIT = 11;
  localparam int TX_SRC_LSB = 12;
  localparam int TX_SRC_MSB = 13;
  localparam int CLK_SUBST_BIT = 14;
  localparam int SOFT_RESET_BIT = 15;
  // Field positions in the main status word
  localparam int SERVICE_BIT = 7;
  // Mandatory reserved pattern
  localparam logic [5:0] RESV_PATTERN = 6'h20;
  // Number of modules that can raise a service request
  localparam int NUM_MODULES = 5;
  // Reset hold: 2 us at the 4 ns master clock, rounded up
  localparam int RESET_HOLD_NS = 2000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock source selection for the primary transmit clock
  typedef enum logic [1:0] {
    MCR_SRC_EXTERNAL = 2'h0,
    MCR_SRC_DIV2 = 2'h1,
    MCR_SRC_DIV4 = 2'h2,
    MCR_SRC_SECONDARY = 2'h3
  } mcr_tx_src_e;
endpackage

// >>> common/mcr_if.sv
`timescale 1ns/100ps
// ****************************************
// Host port between processor and device
// ****************************************
interface mcr_if;
  logic [15:0] addr;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic [15:0] data_to_dev;
  logic [15:0] data_from_dev;
  logic data_oe;
  logic irq_n;
  // Host end drives the request pins
  modport host (output addr, output cs_n, output wr_n, output rd_n, output data_to_dev,
                input data_from_dev, input data_oe, input irq_n);
  // Device end answers reads and raises the interrupt
  modport dev (input addr, input cs_n, input wr_n, input rd_n, input data_to_dev,
               output data_from_dev, output data_oe, output irq_n);
endinterface

// >>> verilog/mcr_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: Bits 4..0 enable each module's interrupts
// R2: Host writes reserved bits 10..5 as 100000
// R3: Host sets page access bit 11
// R4: Bits 13:12 pick primary transmit clock source
// R5: Bit 14 low substitutes master/4 clocks
// R6: Host sets bit 14 before reset release
// R7: Bit 15 low holds modules in reset
// R8: Reset synchronous; master clock must keep running
// R9: Host holds reset at least 2 us
// R10: Host releases soft reset before other accesses
// R11: Control word resets to zero
// R12: Interrupt needs status, module mask, main enable
// R13: Summary service bit is OR of five
// R14: Control word reads back last written value
module mcr_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host port
  mcr_if.dev bus,
  // Module service requests, already masked inside each module
  input wire logic [4:0] module_service_req,
  // Secondary transmit clock and external clocks, sampled
  input wire logic secondary_tx_clock,
  input wire logic [3:0] external_clocks,
  // Primary transmit clock pin, three signals
  input wire logic primary_tx_clock_in,
  output logic primary_tx_clock_out,
  output logic primary_tx_clock_oe,
  // Clocks handed to inner modules
  output logic [3:0] module_clocks,
  // Reset held on every module but the host port
  output logic module_reset_n
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] main_control;    // Control word
    logic [1:0] div_cnt;          // Master clock divider
    logic [1:0] wr_hist;          // Write strobe history
    logic [1:0] rd_hist;          // Read strobe history
    logic [15:0] rd_data;         // Read data latch
    logic rd_oe;                  // Drive data bus
    logic irq;                    // Interrupt level
    logic tx_clk;                 // Primary clock output
    logic [3:0] mod_clk;          // Module clocks
    logic [1:0] sec_sync;         // Secondary clock synchroniser
    logic [7:0] ext_sync;         // External clocks synchroniser, two stages
    logic [9:0] svc_sync;         // Service request synchroniser
    logic [31:0] req_sync;        // cs, wr, rd, pad; host strobes pass two stages
    logic [15:0] addr_q;          // Sampled address
    logic [15:0] data_q;          // Sampled write data
  } mcr_dev_s;
  mcr_dev_s st;
  mcr_dev_s next_st;
  logic [4:0] svc;
  logic [3:0] ext;
  logic sec;
  logic cs_ok;
  logic wr_ok;
  logic rd_ok;
  logic wr_edge;
  logic rd_edge;
  logic [7:0] status_word;
  mcr_pkg::mcr_tx_src_e src;
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Two flip-flop synchronisers on secondary and external clocks, service requests and strobes; address and data sampled once
    next_st.sec_sync = {st.sec_sync[0], secondary_tx_clock};
    next_st.ext_sync = {st.ext_sync[3:0], external_clocks};
    next_st.svc_sync = {st.svc_sync[4:0], module_service_req};
    next_st.req_sync = {st.req_sync[15:0], 13'h0000, ~bus.cs_n, ~bus.wr_n, ~bus.rd_n};
    next_st.addr_q = bus.addr;
    next_st.data_q = bus.data_to_dev;
    // Second stages only
    svc = st.svc_sync[9:5];
    ext = st.ext_sync[7:4];
    sec = st.sec_sync[1];
    cs_ok = st.req_sync[18];
    wr_ok = st.req_sync[17];
    rd_ok = st.req_sync[16];
    next_st.wr_hist = {st.wr_hist[0], cs_ok & wr_ok};
    next_st.rd_hist = {st.rd_hist[0], cs_ok & rd_ok};
    wr_edge = st.wr_hist[0] & ~st.wr_hist[1];
    rd_edge = st.rd_hist[0] & ~st.rd_hist[1];
    // Address and data were captured long before the strobe settles
    // R14: full word stored
    if (wr_edge && st.addr_q == mcr_pkg::MAIN_CONTROL_ADDR) begin
      next_st.main_control = st.data_q;
    end
    // Summary status word
    // R13: summary service bit
    status_word = {|svc, 2'h0, svc};
    if (rd_edge) begin
      if (st.addr_q == mcr_pkg::MAIN_CONTROL_ADDR) begin
        next_st.rd_data = st.main_control;
      end else if (st.addr_q == mcr_pkg::MAIN_STATUS_ADDR) begin
        next_st.rd_data = {8'h00, status_word};
      end else begin
        // Unmapped words read zero
        next_st.rd_data = 16'h0000;
      end
    end
    next_st.rd_oe = st.rd_hist[0];
    // R12: masked interrupt
    // R1: per-module enables
    next_st.irq = |(svc & st.main_control[mcr_pkg::IRQ_EN_MSB:mcr_pkg::IRQ_EN_LSB]);
    next_st.div_cnt = st.div_cnt + 2'h1;
    // R5: clock substitution
    if (st.main_control[mcr_pkg::CLK_SUBST_BIT]) begin
      next_st.mod_clk = ext;
    end else begin
      next_st.mod_clk = {4{st.div_cnt[1]}};
    end
    // R4: transmit clock source
    src = mcr_pkg::mcr_tx_src_e'(st.main_control[mcr_pkg::TX_SRC_MSB:mcr_pkg::TX_SRC_LSB]);
    unique case (src)
      mcr_pkg::MCR_SRC_EXTERNAL: begin
        next_st.tx_clk = 1'b0;
      end
      mcr_pkg::MCR_SRC_DIV2: begin
        next_st.tx_clk = st.div_cnt[0];
      end
      mcr_pkg::MCR_SRC_DIV4: begin
        next_st.tx_clk = st.div_cnt[1];
      end
      mcr_pkg::MCR_SRC_SECONDARY: begin
        // Secondary clock is itself substituted while bit 14 is low
        next_st.tx_clk = st.main_control[mcr_pkg::CLK_SUBST_BIT] ? sec : st.div_cnt[1];
      end
    endcase
  end
  // ****************************************
  // Registers
  // ****************************************
  // R8: synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // R11: zero at reset
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign bus.data_from_dev = st.rd_data;
  assign bus.data_oe = st.rd_oe;
  assign bus.irq_n = ~st.irq;
  assign primary_tx_clock_out = st.tx_clk;
  // Pin released to an external oscillator in source zero
  assign primary_tx_clock_oe =
    (st.main_control[mcr_pkg::TX_SRC_MSB:mcr_pkg::TX_SRC_LSB] != 2'h0);
  assign module_clocks = st.mod_clk;
  // R7: soft reset hold
  assign module_reset_n = st.main_control[mcr_pkg::SOFT_RESET_BIT];
  // Pin input kept for loopback sampling elsewhere; unused here
  logic unused_pin;
  assign unused_pin = primary_tx_clock_in;
endmodule

// >>> verilog/mcr_host.sv
`timescale 1ns/100ps
module mcr_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host port
  mcr_if.host bus,
  // User command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic init_done,
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    HST_HOLD, HST_CFG_SUBST, HST_RELEASE, HST_IDLE, HST_ACCESS, HST_GAP
  } mcr_hst_e;
  typedef struct packed {
    mcr_hst_e fsm;
    logic [9:0] cnt;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic active;
    logic rsp;
    logic [15:0] rdata;
    logic [1:0] irq_sync;
  } mcr_host_s;
  mcr_host_s st;
  mcr_host_s next_st;
  logic [15:0] base_word;
  // Legal fixed fields: pattern, page bit; sources left at zero
  always_comb begin
    base_word = 16'h0000;
    // R2: reserved pattern
    base_word[mcr_pkg::RESV_MSB:mcr_pkg::RESV_LSB] = mcr_pkg::RESV_PATTERN;
    // R3: page access set
    base_word[mcr_pkg::PAGE_ACCESS_BIT] = 1'b1;
  end
  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rsp = 1'b0;
    next_st.irq_sync = {st.irq_sync[0], ~bus.irq_n};
    unique case (st.fsm)
      HST_HOLD: begin
        // R9: hold reset interval
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt == 10'(mcr_pkg::RESET_HOLD_CYCLES)) begin
          next_st.fsm = HST_CFG_SUBST;
          next_st.cnt = 10'h000;
        end
      end
      HST_CFG_SUBST: begin
        // R6: clocks normal first
        next_st.addr = mcr_pkg::MAIN_CONTROL_ADDR;
        next_st.wdata = base_word | 16'h4000;
        next_st.wr = 1'b1;
        next_st.active = 1'b1;
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt == 10'h00f) begin
          next_st.active = 1'b0;
          next_st.cnt = 10'h000;
          next_st.fsm = HST_RELEASE;
        end
      end
      HST_RELEASE: begin
        // R10: release before other access
        next_st.wdata = base_word | 16'hc000;
        next_st.active = (st.cnt >= 10'h004) && (st.cnt < 10'h013);
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt == 10'h017) begin
          next_st.cnt = 10'h000;
          next_st.fsm = HST_IDLE;
        end
      end
      HST_IDLE: begin
        if (cmd_valid) begin
          next_st.addr = cmd_addr;
          next_st.wdata = cmd_wdata;
          next_st.wr = cmd_write;
          next_st.active = 1'b1;
          next_st.fsm = HST_ACCESS;
        end
      end
      HST_ACCESS: begin
        // Strobe long enough for the device synchronisers
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt == 10'h00f) begin
          next_st.rdata = bus.data_from_dev;
          next_st.rsp = 1'b1;
          next_st.active = 1'b0;
          next_st.cnt = 10'h000;
          next_st.fsm = HST_GAP;
        end
      end
      HST_GAP: begin
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt == 10'h007) begin
          next_st.cnt = 10'h000;
          next_st.fsm = HST_IDLE;
        end
      end
    endcase
  end
  // R8: synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '{fsm: HST_HOLD, default: '0};
    end else begin
      st <= next_st;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign bus.addr = st.addr;
  assign bus.data_to_dev = st.wdata;
  assign bus.cs_n = ~st.active;
  assign bus.wr_n = ~(st.active & st.wr);
  assign bus.rd_n = ~(st.active & ~st.wr);
  assign cmd_ready = (st.fsm == HST_IDLE);
  assign rsp_valid = st.rsp;
  assign rsp_rdata = st.rdata;
  assign init_done = (st.fsm == HST_IDLE) || (st.fsm == HST_ACCESS) || (st.fsm == HST_GAP);
  assign irq = st.irq_sync[1];
endmodule

// >>> dv/mcr_properties.sv
`timescale 1ns/100ps
// ****
// Host port checks
// ****
module mcr_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host port signals
  input wire logic [15:0] addr,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [15:0] data_to_dev,
  input wire logic [15:0] data_from_dev,
  input wire logic data_oe,
  input wire logic irq_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // 2 us of hold, less the bench's own reset cycles
  localparam int HOLD_MIN = 488;
  int hold; // Cycles since release
  int nwr; // Writes started
  int quiet; // Cycles with all enables off
  logic cs_q; // Strobe one cycle ago
  logic [15:0] shadow; // Last control word sent
  wire wr_go = cs_q && !cs_n && !wr_n;
  // Helper counters, cleared by reset except quiet
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hold <= 0;
      nwr <= 0;
      cs_q <= 1'b1;
      shadow <= 16'h0000;
    end else begin
      cs_q <= cs_n;
      hold <= (hold < 600) ? hold + 1 : hold;
      nwr <= wr_go ? nwr + 1 : nwr;
      if (wr_go && addr == mcr_pkg::MAIN_CONTROL_ADDR) begin
        shadow <= data_to_dev;
      end
    end
    quiet <= (shadow[4:0] != 5'h00) ? 0 : ((quiet < 40) ? quiet + 1 : quiet);
  end
  property p_reset_idle; $rose(reset_n) |-> !data_oe && irq_n && cs_n; endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("port not idle after reset");
  property p_hold; hold < HOLD_MIN |-> cs_n; endproperty
  a_hold: assert property (p_hold)
    else $error("access during reset hold");
  property p_first_wr; wr_go && nwr == 0 |-> addr == 16'h0000 && data_to_dev == 16'h4c00;
  endproperty
  a_first_wr: assert property (p_first_wr)
    else $error("first write wrong");
  property p_second_wr; wr_go && nwr == 1 |-> addr == 16'h0000 && data_to_dev == 16'hcc00;
  endproperty
  a_second_wr: assert property (p_second_wr)
    else $error("second write wrong");
  property p_readback; $rose(data_oe) && addr == 16'h0000 |-> data_from_dev == shadow;
  endproperty
  a_readback: assert property (p_readback)
    else $error("control readback differs");
  property p_status; $rose(data_oe) && addr == 16'h0002 |->
    data_from_dev[15:8] == 8'h00 && data_from_dev[7] == |data_from_dev[4:0]; endproperty
  a_status: assert property (p_status)
    else $error("status word malformed");
  property p_irq_off; quiet > 16 |-> irq_n; endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with enables off");
  property p_oe_release; $rose(rd_n) |-> ##[1:5] !data_oe; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("data bus not released");
endmodule

// >>> dv/main_control_reset_irq_enable_bench.sv
`timescale 1ns/100ps
module main_control_reset_irq_enable_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_ready, rsp_valid, init_done, irq;
  logic [15:0] rsp_rdata;
  logic [4:0] module_service_req = 5'h00;
  logic secondary_tx_clock = 1'b0;
  logic [3:0] external_clocks = 4'h5;
  logic primary_tx_clock_in = 1'b0; // Unused by the device
  logic primary_tx_clock_out, primary_tx_clock_oe, module_reset_n;
  logic [3:0] module_clocks;
  logic [1:0] sc_cnt = 2'h0;
  logic [31:0] seed = 32'h00014445;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  mcr_if bus_if ();
  mcr_device mcr_device_i (.ref_clk, .reset_n, .bus(bus_if), .module_service_req,
    .secondary_tx_clock, .external_clocks, .primary_tx_clock_in, .primary_tx_clock_out,
    .primary_tx_clock_oe, .module_clocks, .module_reset_n);
  mcr_host mcr_host_i (.ref_clk, .reset_n, .bus(bus_if), .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .init_done, .irq);
  mcr_properties mcr_properties_i (.ref_clk, .reset_n, .addr(bus_if.addr),
    .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
    .data_to_dev(bus_if.data_to_dev), .data_from_dev(bus_if.data_from_dev),
    .data_oe(bus_if.data_oe), .irq_n(bus_if.irq_n));
  initial forever #2 ref_clk = ~ref_clk;
  // Secondary clock toggles every 4 cycles
  always @(negedge ref_clk) begin
    sc_cnt <= sc_cnt + 2'h1;
    if (sc_cnt == 2'h3) secondary_tx_clock <= ~secondary_tx_clock;
  end
  // Hang guard, far above the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rng();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected transitions in 16 cycles per source
  function automatic logic [15:0] toggles(int s);
    return (s == 1) ? 16'h10 : (s == 2) ? 16'h8 : (s == 3) ? 16'h4 : 16'h0;
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // One command, held until taken, then spaced out
  task automatic access(logic w, logic [15:0] a, logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
    if (n == 40) errors++;
    q = rsp_rdata;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    logic [15:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] exp, string name);
    logic [15:0] q;
    access(1'b0, a, 16'h0000, q);
    check(name, q, exp);
  endtask
  // Count changes on the transmit and first module clock
  task automatic measure(output int np, output int nm);
    logic p, m;
    np = 0;
    nm = 0;
    p = primary_tx_clock_out;
    m = module_clocks[0];
    repeat (16) begin
      @(negedge ref_clk);
      np += int'(primary_tx_clock_out !== p);
      nm += int'(module_clocks[0] !== m);
      p = primary_tx_clock_out;
      m = module_clocks[0];
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    int np, nm, n;
    logic [4:0] en, rq;
    repeat (12) @(negedge ref_clk);
    check("mod_rst", 16'(module_reset_n), 16'h0);
    check("tx_oe", 16'(primary_tx_clock_oe), 16'h0);
    reset_n = 1'b1;
    for (n = 0; n < 2000 && init_done !== 1'b1; n++) @(negedge ref_clk);
    check("mod_rst", 16'(module_reset_n), 16'h1);
    rd(16'h0000, 16'hcc00, "ctrl");
    external_clocks = 4'(rng());
    for (int s = 0; s < 4; s++) begin
      wr(16'h0000, 16'hcc00 | 16'(s << 12));
      check("tx_oe", 16'(primary_tx_clock_oe), 16'(s != 0));
      measure(np, nm);
      check("tx_tog", 16'(np), toggles(s));
      check("mod_clk", 16'(module_clocks), 16'(external_clocks));
    end
    wr(16'h0000, 16'hbc00);
    measure(np, nm);
    check("sub_tx", 16'(np), 16'h8);
    check("sub_mod", 16'(nm), 16'h8);
    // Other words are only touched while modules run
    wr(16'h0002, 16'hffff);
    rd(16'h0010, 16'h0000, "unmapped");
    wr(16'h0000, 16'h4c00);
    check("mod_rst", 16'(module_reset_n), 16'h0);
    rd(16'h0000, 16'h4c00, "ctrl");
    for (int i = 0; i < 10; i++) begin
      en = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : 5'(rng());
      rq = (i < 2) ? 5'h1f : 5'(rng());
      wr(16'h0000, 16'hcc00 | 16'(en));
      module_service_req = rq;
      repeat (16) @(negedge ref_clk);
      check("irq", 16'(irq), 16'(|(en & rq)));
      rd(16'h0002, {8'h00, |rq, 2'b00, rq}, "status");
      rd(16'h0000, 16'hcc00 | 16'(en), "ctrl");
    end
    tally_and_finish();
  end
endmodule
